// ---- hdl/vdp_pkg.sv ----
// Shared constants, modes and the pixel carrier for the pixel output port.
`default_nettype none
package vdp_pkg;
	// --------------------------------------------------------------
	// Output modes, chosen by configuration before streaming.
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		VDP_MODE_24,      // One pixel per data clock on the primary buses.
		VDP_MODE_422,     // Luma with alternating chroma on the primary buses.
		VDP_MODE_48       // Two pixels per data clock, primary then secondary.
	} vdp_mode_t;

	// One pixel: three 8-bit channel samples.
	typedef struct packed {
		logic [7:0] r;    // Red (or Pr) sample.
		logic [7:0] g;    // Green (or Y) sample.
		logic [7:0] b;    // Blue (or Pb) sample.
	} vdp_rgb_t;

	// --------------------------------------------------------------
	// Timing.
	// --------------------------------------------------------------
	localparam int          CLK_PERIOD_PS = 5000;  // System clock period, 200 MHz.
	localparam int          RST_MIN_US    = 1;     // Least reset low time.
	localparam int          RST_HOLD_CYC  = (RST_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [7:0]  RST_HOLD_CNT  = 8'(RST_HOLD_CYC);  // Settle count after release.
	localparam logic [3:0]  FS_DELAY_PIX  = 4'h8;  // Pixel clocks from line sync trailing edge.
	localparam logic [3:0]  FS_LAST       = 4'h1;  // Counter value on the final pixel clock.
	localparam logic [7:0]  PIX_ZERO      = 8'h00; // Value on unused buses.
endpackage
`default_nettype wire

// ---- hdl/vdp_pixel_port.sv ----
// Pixel output port: pixel buses, forwarded data clock, aligned syncs and crystal clock buffer.
`timescale 1ns/1ps
`default_nettype none
module vdp_pixel_port (
	input  wire logic             clk_sys,                    // System clock, 200 MHz.
	input  wire logic             rst_b,                      // Asynchronous reset, active low.
	input  wire vdp_pkg::vdp_mode_t out_mode,                 // Output mode, static while streaming.
	input  wire vdp_pkg::vdp_rgb_t  sample_in,                // Digitized pixel, valid every cycle.
	input  wire logic             raw_line_sync,              // Line sync from the sync processor.
	input  wire logic             sync_serration,             // High while composite pulses are present.
	input  wire logic             raw_frame_sync,             // Frame sync level from the sync processor.
	input  wire logic             sample_phase_invert,        // Pin: invert sampling phase.
	input  wire logic             xtal_clk,                   // Pin: crystal oscillator clock.
	input  wire logic             xtal_div2_sel,              // High selects crystal clock divided by two.
	output logic [7:0]            red_primary_bus,            // Red primary pixel data.
	output logic [7:0]            green_primary_bus,          // Green primary pixel data.
	output logic [7:0]            blue_primary_bus,           // Blue primary pixel data.
	output logic [7:0]            red_secondary_bus,          // Red secondary pixel data.
	output logic [7:0]            green_secondary_bus,        // Green secondary pixel data.
	output logic [7:0]            blue_secondary_bus,         // Blue secondary pixel data.
	output logic                  forwarded_pixel_clock,      // Forwarded data clock.
	output logic                  forwarded_pixel_clock_inv,  // Inverse of the data clock.
	output logic                  aligned_line_sync,          // Line sync aligned with pixel data.
	output logic                  aligned_frame_sync,         // Artificial frame sync.
	output logic                  crystal_clock_buffer_out    // Buffered crystal clock.
);
	// --------------------------------------------------------------
	// Declarations.
	// --------------------------------------------------------------
	logic [7:0]        hold_cnt_r;       // Settle counter after reset release.
	logic              run_r;            // High once the settle time has passed.
	logic              inv_s1_r;         // Phase invert synchroniser, first stage.
	logic              inv_s2_r;         // Second stage.
	logic              inv_s3_r;         // Third stage.
	logic              inv_lvl_r;        // Accepted phase invert level.
	logic              phase_r;          // Pixel clock divider phase.
	logic              pair_sel_r;       // High when the held pixel waits for its partner.
	logic              cb_sel_r;         // Chroma selector for 4:2:2.
	vdp_pkg::vdp_rgb_t held_r;           // First pixel of a 48-bit pair.
	vdp_pkg::vdp_rgb_t pri_r;            // Primary bus register.
	vdp_pkg::vdp_rgb_t sec_r;            // Secondary bus register.
	vdp_pkg::vdp_rgb_t pri_nxt;          // Next primary value.
	vdp_pkg::vdp_rgb_t sec_nxt;          // Next secondary value.
	logic              fclk_r;           // Forwarded clock register.
	logic              fclk_inv_r;       // Inverse clock register.
	logic              fclk_nxt;         // Next forwarded clock value.
	logic              line_r;           // Aligned line sync register.
	logic              line_prev_r;      // Previous aligned line sync.
	logic [3:0]        fs_cnt_r;         // Frame sync delay counter.
	logic              frame_r;          // Aligned frame sync register.
	logic              xs1_r;            // Crystal clock synchroniser, first stage.
	logic              xs2_r;            // Second stage.
	logic              xs3_r;            // Third stage.
	logic              xlvl_r;           // Accepted crystal clock level.
	logic              xdiv_r;           // Crystal clock halved.
	logic              xout_r;           // Buffered crystal clock register.

	// --------------------------------------------------------------
	// Decode and selection.
	// --------------------------------------------------------------
	wire is48      = (out_mode == vdp_pkg::VDP_MODE_48);
	wire is422     = (out_mode == vdp_pkg::VDP_MODE_422);
	// The invert level picks the other divider phase, a half pixel later.
	wire pixel_en  = run_r & (phase_r ^ inv_lvl_r);
	// Composite pulses are stripped before alignment.
	wire line_q    = raw_line_sync & ~sync_serration;
	// Buses update once per pixel, or once per pair in 48-bit mode.
	wire upd       = pixel_en & (~is48 | pair_sel_r);
	wire trailing  = line_prev_r & ~line_r;
	wire inv_take  = (inv_s2_r == inv_s3_r);
	wire x_take    = (xs2_r == xs3_r);
	wire x_rise    = x_take & xs3_r & ~xlvl_r;
	wire xlvl_nxt  = x_take ? xs3_r : xlvl_r;
	wire xdiv_nxt  = x_rise ? ~xdiv_r : xdiv_r;
	wire [7:0] chroma = cb_sel_r ? sample_in.b : sample_in.r;

	// Bus contents per mode; in 48-bit mode the held pixel leads.
	// Typed patterns, since a bare pattern has no type inside a conditional operand.
	assign pri_nxt  = is48  ? held_r :
	                  is422 ? vdp_pkg::vdp_rgb_t'{r: vdp_pkg::PIX_ZERO, g: sample_in.g, b: chroma} : sample_in;
	assign sec_nxt  = is48  ? sample_in :
	                  vdp_pkg::vdp_rgb_t'{r: vdp_pkg::PIX_ZERO, g: vdp_pkg::PIX_ZERO, b: vdp_pkg::PIX_ZERO};
	// Falls as new data lands, rises mid-word so the receiver samples a settled bus.
	assign fclk_nxt = upd ? 1'b0 : (is48 ? (pixel_en | fclk_r) : run_r);

	// --------------------------------------------------------------
	// Reset settle: all outputs but the crystal clock buffer stay quiet for the least reset time after release.
	// --------------------------------------------------------------
	// A pin tied high never enters this path after power-up reset.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hold_cnt_r <= 8'h00;
			run_r      <= 1'b0;
		end else if (!run_r) begin
			hold_cnt_r <= hold_cnt_r + 8'h01;
			run_r      <= (hold_cnt_r == vdp_pkg::RST_HOLD_CNT);
		end
	end

	// --------------------------------------------------------------
	// Phase invert pin: three stages, change taken when stages two and three agree.
	// --------------------------------------------------------------
	// A change costs at most one doubled or skipped pixel, so the host toggles it in frame sync.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			inv_s1_r  <= 1'b0;
			inv_s2_r  <= 1'b0;
			inv_s3_r  <= 1'b0;
			inv_lvl_r <= 1'b0;
		end else begin
			inv_s1_r  <= sample_phase_invert;
			inv_s2_r  <= inv_s1_r;
			inv_s3_r  <= inv_s2_r;
			inv_lvl_r <= inv_take ? inv_s3_r : inv_lvl_r;
		end
	end

	// --------------------------------------------------------------
	// Pixel divider, pairing and chroma order.
	// --------------------------------------------------------------
	// Pair and chroma order restart in line sync so each line starts on a primary word.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase_r    <= 1'b0;
			pair_sel_r <= 1'b0;
			cb_sel_r   <= 1'b1;
			held_r     <= '0;
		end else begin
			phase_r <= run_r ? ~phase_r : 1'b0;
			if (pixel_en) begin
				pair_sel_r <= is48 & ~line_q & ~pair_sel_r;
				cb_sel_r   <= line_q | ~cb_sel_r;
				held_r     <= sample_in;
			end
		end
	end

	// --------------------------------------------------------------
	// Output registers: buses, line sync and the clock pair move together.
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pri_r      <= '0;
			sec_r      <= '0;
			line_r     <= 1'b0;
			fclk_r     <= 1'b0;
			fclk_inv_r <= 1'b1;
		end else begin
			if (upd) begin
				pri_r  <= pri_nxt;
				sec_r  <= sec_nxt;
				line_r <= line_q;
			end
			fclk_r     <= fclk_nxt;
			fclk_inv_r <= ~fclk_nxt;
		end
	end

	// --------------------------------------------------------------
	// Artificial frame sync, placed a fixed pixel count after the line trailing edge.
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			line_prev_r <= 1'b0;
			fs_cnt_r    <= 4'h0;
			frame_r     <= 1'b0;
		end else begin
			line_prev_r <= line_r;
			if (trailing) begin
				fs_cnt_r <= vdp_pkg::FS_DELAY_PIX;
			end else if (pixel_en && fs_cnt_r != 4'h0) begin
				fs_cnt_r <= fs_cnt_r - 4'h1;
			end
			if (pixel_en && fs_cnt_r == vdp_pkg::FS_LAST) begin
				frame_r <= raw_frame_sync;
			end
		end
	end

	// --------------------------------------------------------------
	// Crystal clock buffer, oversampled; edges carry up to one cycle of jitter.
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			xs1_r  <= 1'b0;
			xs2_r  <= 1'b0;
			xs3_r  <= 1'b0;
			xlvl_r <= 1'b0;
			xdiv_r <= 1'b0;
			xout_r <= 1'b0;
		end else begin
			xs1_r  <= xtal_clk;
			xs2_r  <= xs1_r;
			xs3_r  <= xs2_r;
			xlvl_r <= xlvl_nxt;
			xdiv_r <= xdiv_nxt;
			xout_r <= xtal_div2_sel ? xdiv_nxt : xlvl_nxt;
		end
	end

	assign red_primary_bus           = pri_r.r;
	assign green_primary_bus         = pri_r.g;
	assign blue_primary_bus          = pri_r.b;
	assign red_secondary_bus         = sec_r.r;
	assign green_secondary_bus       = sec_r.g;
	assign blue_secondary_bus        = sec_r.b;
	assign forwarded_pixel_clock     = fclk_r;
	assign forwarded_pixel_clock_inv = fclk_inv_r;
	assign aligned_line_sync         = line_r;
	assign aligned_frame_sync        = frame_r;
	assign crystal_clock_buffer_out  = xout_r;

	// --------------------------------------------------------------
	// Assertions.
	// --------------------------------------------------------------
	default clocking cb_sys @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence seq_clk_high_two;
		forwarded_pixel_clock ##1 forwarded_pixel_clock ##1 !forwarded_pixel_clock;
	endsequence

	AST_PRIMARY_24: assert property (upd && out_mode == vdp_pkg::VDP_MODE_24 |=>
		red_primary_bus == $past(sample_in.r) && blue_primary_bus == $past(sample_in.b))
		else $error("Primary bus does not carry the sample in 24-bit mode.");
	AST_PAIR_48: assert property (upd && is48 |=>
		green_secondary_bus == $past(sample_in.g) && green_primary_bus == $past(held_r.g))
		else $error("48-bit pair order broken.");
	// A phase invert step repeats one divider state, so the cycle right after it is excused.
	AST_CLK_24: assert property (run_r && !is48 && $past(run_r, 2) && $stable(out_mode) &&
		$past(inv_lvl_r) == $past(inv_lvl_r, 2) |->
		forwarded_pixel_clock != $past(forwarded_pixel_clock))
		else $error("Data clock not at pixel rate in 24-bit mode.");
	AST_CLK_48: assert property (is48 && $stable(out_mode) && $rose(forwarded_pixel_clock) |->
		seq_clk_high_two)
		else $error("Data clock not at half rate in 48-bit mode.");
	AST_CLK_INV: assert property (forwarded_pixel_clock_inv == !forwarded_pixel_clock)
		else $error("Inverse data clock is not the inverse.");
	AST_LINE_ALIGN: assert property (upd |=> aligned_line_sync == $past(line_q))
		else $error("Line sync not aligned with pixel data.");
	AST_NO_COMPOSITE: assert property (upd && sync_serration |=> !aligned_line_sync)
		else $error("Composite pulse passed on line sync.");
	AST_PHASE: assert property (run_r && pixel_en |=> !pixel_en || $changed(inv_lvl_r))
		else $error("Pixel sampling phase not steady.");
	// An invert step moves the pixel strobe by one system cycle, half a pixel period.
	AST_PHASE_SHIFT: assert property (run_r && $past(run_r) && $changed(inv_lvl_r) |->
		pixel_en == $past(pixel_en))
		else $error("Phase invert did not shift the sampling phase.");
	AST_SETTLE: assert property (!run_r |-> red_primary_bus == vdp_pkg::PIX_ZERO && !forwarded_pixel_clock)
		else $error("Outputs active during reset settle.");
	AST_FS_LOAD: assert property (trailing |=> fs_cnt_r == vdp_pkg::FS_DELAY_PIX)
		else $error("Frame sync delay not started on line trailing edge.");
	AST_FS_SET: assert property (pixel_en && fs_cnt_r == vdp_pkg::FS_LAST && !trailing |=>
		aligned_frame_sync == $past(raw_frame_sync) && fs_cnt_r == 4'h0)
		else $error("Frame sync not taken at end of delay.");
	AST_XTAL_DIRECT: assert property (!xtal_div2_sel |=> crystal_clock_buffer_out == xlvl_r)
		else $error("Crystal buffer does not follow the crystal.");
endmodule
`default_nettype wire

// ---- sim/vdp_rx_model.sv ----
// Downstream receiver model that takes each pixel word on the forwarded clock.
`timescale 1ns/1ps
`default_nettype none
module vdp_rx_model (
	input  wire logic              fclk,     // Forwarded data clock.
	input  wire vdp_pkg::vdp_rgb_t pri,      // Primary buses.
	input  wire vdp_pkg::vdp_rgb_t sec,      // Secondary buses.
	input  wire logic              lsync,    // Aligned line sync.
	output var  vdp_pkg::vdp_rgb_t cap_pri,  // Captured primary word.
	output var  vdp_pkg::vdp_rgb_t cap_sec,  // Captured secondary word.
	output var  logic              cap_ls    // Line sync seen with the word.
);
	// --------------------------------------------------------------
	// Capture.
	// --------------------------------------------------------------
	// Words are taken on the rising edge, mid-word, where setup and hold margins are widest.
	always @(posedge fclk) begin
		cap_pri <= pri;
		cap_sec <= sec;
		cap_ls  <= lsync;
	end
endmodule
`default_nettype wire

// ---- sim/vdp_pixel_port_tb.sv ----
// Self-checking bench for the pixel output port.
`timescale 1ns/1ps
`default_nettype none
module vdp_pixel_port_tb;
	// --------------------------------------------------------------
	// Signals and bench state.
	// --------------------------------------------------------------
	logic               clk_sys = 1'b0;                  // System clock.
	logic               rst_b = 1'b0;                    // Reset, active low.
	vdp_pkg::vdp_mode_t out_mode = vdp_pkg::VDP_MODE_24; // Output mode.
	vdp_pkg::vdp_rgb_t  sample_in = 24'h000000;          // Pixel stimulus.
	logic               raw_line_sync = 1'b0, sync_serration = 1'b0, raw_frame_sync = 1'b0;
	logic               ph_inv = 1'b0, xtal = 1'b0, xsel = 1'b0;
	logic               ls_rand = 1'b0, ls_force = 1'b0, chk_on = 1'b0, fclk_q = 1'b0;
	logic [7:0]         rp, gp, bp, rs, gs, bs;          // Pixel buses.
	logic               fclk, fclk_n, als, afs, xout;    // Clock and sync outputs.
	vdp_pkg::vdp_rgb_t  cap_pri, cap_sec, ea, eb;        // Captured and expected words.
	logic               cap_ls;                          // Captured line sync.
	vdp_pkg::vdp_rgb_t  hist [16];                       // Stimulus of the last cycles.
	logic               hist_ls [16];                    // Expected line sync per cycle.
	int                 cyc = 0, seed = 32'hb4a4, miscompares = 0, samples_checked = 0;
	int                 lat_ref = -1, last_cap = 0, cap_n = 0, n = 0;

	always #2.5 clk_sys = ~clk_sys;
	// Crystal runs unrelated in phase to the system clock.
	always #19.7 xtal = ~xtal;

	vdp_pixel_port vdp_pixel_port_inst (.clk_sys(clk_sys), .rst_b(rst_b), .out_mode(out_mode),
		.sample_in(sample_in), .raw_line_sync(raw_line_sync), .sync_serration(sync_serration),
		.raw_frame_sync(raw_frame_sync), .sample_phase_invert(ph_inv), .xtal_clk(xtal), .xtal_div2_sel(xsel),
		.red_primary_bus(rp), .green_primary_bus(gp), .blue_primary_bus(bp), .red_secondary_bus(rs),
		.green_secondary_bus(gs), .blue_secondary_bus(bs), .forwarded_pixel_clock(fclk),
		.forwarded_pixel_clock_inv(fclk_n), .aligned_line_sync(als), .aligned_frame_sync(afs),
		.crystal_clock_buffer_out(xout));
	vdp_rx_model vdp_rx_model_inst (.fclk(fclk), .pri({rp, gp, bp}), .sec({rs, gs, bs}), .lsync(als),
		.cap_pri(cap_pri), .cap_sec(cap_sec), .cap_ls(cap_ls));

	// --------------------------------------------------------------
	// Shared tasks.
	// --------------------------------------------------------------
	task automatic check_val(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Waits whole cycles and lands 1 ns after the edge, where inputs change.
	task automatic cycles(input int c);
		repeat (c) @(posedge clk_sys);
		#1;
	endtask
	// A wait that used up its bound ends the run at once.
	task automatic guard();
		if (n >= 50) begin
			miscompares++;
			print_verdict();
		end
	endtask
	// Resets with a new mode, since the mode may only change while idle.
	task automatic do_reset(input vdp_pkg::vdp_mode_t m);
		chk_on = 1'b0;
		lat_ref = -1;
		cap_n = 0;
		rst_b = 1'b0;
		out_mode = m;
		cycles(10);
		check_val("reset outputs", {rp, gp, bp, rs, gs, bs, fclk, fclk_n, als, afs}, 64'h4);
		// Released, then left high for the rest of the scenario.
		rst_b = 1'b1;
		cycles(150);
		check_val("settle outputs", {rp, gp, bp, rs, gs, bs, fclk, fclk_n, als, afs}, 64'h4);
		cycles(80);
		chk_on = 1'b1;
	endtask
	// Counts buffered crystal rises over 400 cycles, about 2 us.
	task automatic xtal_rate(input logic div, input int lo, input int hi);
		int  rises;
		logic q;
		rises = 0;
		xsel = div;
		cycles(40);
		q = xout;
		repeat (400) begin
			cycles(1);
			if (xout === 1'b1 && q === 1'b0) rises++;
			q = xout;
		end
		check_val("crystal rate", (rises >= lo) && (rises <= hi), 1'b1);
	endtask

	// --------------------------------------------------------------
	// Stimulus: random red and blue, green counts so each word can be located in the history.
	// --------------------------------------------------------------
	always @(posedge clk_sys) begin
		#1;
		cyc++;
		sample_in = {8'($random(seed)), 8'(cyc), 8'($random(seed))};
		if (!ls_rand) begin
			raw_line_sync = ls_force;
			sync_serration = 1'b0;
		end else if (cyc % 8 == 0) begin
			raw_line_sync = ($random(seed) % 3 == 0) && (out_mode != vdp_pkg::VDP_MODE_48);
			sync_serration = ($random(seed) % 4 == 0);
		end
		hist[cyc % 16] = sample_in;
		hist_ls[cyc % 16] = raw_line_sync & ~sync_serration;
	end

	// --------------------------------------------------------------
	// Monitor: each rise of the data clock hands a word over; latency is learnt after each reset and phase step, then held to.
	// --------------------------------------------------------------
	always @(posedge clk_sys) begin
		#2;
		if (fclk === 1'b1 && fclk_q === 1'b0 && chk_on) begin
			cap_n++;
			if (lat_ref < 0) begin
				for (int i = 0; i < 14; i++) if (hist[(cyc - i) % 16].g === cap_pri.g) lat_ref = i;
			end else begin
				ea = hist[(cyc - lat_ref) % 16];
				eb = hist[(cyc - lat_ref + 2) % 16];
				if (out_mode == vdp_pkg::VDP_MODE_422) begin
					check_val("luma", cap_pri.g, ea.g);
					check_val("unused red", cap_pri.r, 8'h00);
					check_val("chroma", (cap_pri.b === ea.b) || (cap_pri.b === ea.r), 1'b1);
					// A pixel that follows one in line sync always carries the blue chroma sample.
					if (hist_ls[(cyc - lat_ref - 2) % 16]) check_val("chroma after sync", cap_pri.b, ea.b);
				end else begin
					check_val("primary", cap_pri, ea);
				end
				check_val("secondary", cap_sec, (out_mode == vdp_pkg::VDP_MODE_48) ? 24'(eb) : 24'h000000);
				if (out_mode != vdp_pkg::VDP_MODE_48) check_val("line sync", cap_ls, hist_ls[(cyc - lat_ref) % 16]);
				check_val("clock period", cyc - last_cap, (out_mode == vdp_pkg::VDP_MODE_48) ? 4 : 2);
			end
			last_cap = cyc;
		end
		fclk_q = fclk;
		check_val("inverse clock", fclk_n, !fclk);
	end

	// --------------------------------------------------------------
	// Main sequence.
	// --------------------------------------------------------------
	initial begin
		for (int m = 0; m < 3; m++) begin
			do_reset(vdp_pkg::vdp_mode_t'(m));
			ls_rand = 1'b1;
			cycles(300);
			check_val("word flow", cap_n > 50, 1'b1);
		end
		// Phase inversion, toggled while frame sync is high, moves the capture to the other cycle.
		do_reset(vdp_pkg::VDP_MODE_24);
		cycles(100);
		n = last_cap % 2;
		chk_on = 1'b0;
		raw_frame_sync = 1'b1;
		ph_inv = ~ph_inv;
		cycles(20);
		lat_ref = -1;
		chk_on = 1'b1;
		cycles(60);
		check_val("phase shift", last_cap % 2, 1 - n);
		// Frame sync follows the trailing line sync edge by 8 pixel clocks, 16 system cycles.
		ls_rand = 1'b0;
		ls_force = 1'b1;
		cycles(20);
		ls_force = 1'b0;
		raw_frame_sync = ~afs;
		n = 0;
		while (als !== 1'b0 && n < 50) begin
			cycles(1);
			n++;
		end
		guard();
		n = 0;
		while (afs !== raw_frame_sync && n < 50) begin
			cycles(1);
			n++;
		end
		guard();
		check_val("frame sync delay", (n >= 15) && (n <= 17), 1'b1);
		xtal_rate(1'b0, 49, 52);
		xtal_rate(1'b1, 24, 27);
		print_verdict();
	end
endmodule
`default_nettype wire
